// ===== bench/halfbridge_fault_sleep_supervisor_tb.sv
`default_nettype none
module halfbridge_fault_sleep_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b1;
  hbfs_pkg::hbfs_mon_t mon = '0;
  logic [3:0] ocg = 4'h0;
  logic [3:0] be;
  logic pump, rdy, f_o, f_oe, pin_n, f_line;
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  hbfs_supervisor #(.WAKE_DLY_CYC(20), .OCP_CYC(4)) dut (
    .clk(clk), .rst_n(rst_n), .logic_supply_ok(supply_ok),
    .sleep_control_pin_n(pin_n), .mon(mon), .overcurrent_guard(ocg),
    .bridge_enable(be), .pump_enable(pump), .ready_for_inputs(rdy),
    .fault_indicator_out_n_o(f_o), .fault_indicator_out_n_oe(f_oe)
  );
  hbfs_ctrl_model u_ctrl (
    .clk(clk), .fault_o(f_o), .fault_oe(f_oe),
    .sleep_control_pin_n(pin_n), .fault_line(f_line)
  );
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic settle;
    repeat (10) @(negedge clk);
  endtask : settle
  // Bridges, pump and fault line level together
  task automatic outs(input logic [3:0] b, input logic p, input logic f);
    check({2'h0, be, pump, f_line}, {2'h0, b, p, f});
  endtask : outs
  task automatic set_mon(input logic [3:0] v);
    @(negedge clk);
    mon = v;
    settle();
  endtask : set_mon
  task automatic wait_ready;
    int i;
    for (i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge clk);
    check({7'h0, rdy}, 8'h01);
    if (rdy !== 1'b1) finish_test();
  endtask : wait_ready
  task automatic t_supply;
    set_mon(4'h8);
    outs(4'h0, 1'b0, 1'b0);
    set_mon(4'h0);
    outs(4'hf, 1'b1, 1'b1);
  endtask : t_supply
  task automatic t_pump;
    set_mon(4'h4);
    outs(4'h0, 1'b1, 1'b0);
    set_mon(4'h0);
    outs(4'hf, 1'b1, 1'b1);
  endtask : t_pump
  task automatic t_ocp;
    @(negedge clk);
    ocg = 4'h4;
    settle();
    outs(4'hb, 1'b1, 1'b0);
    @(negedge clk);
    ocg = 4'h0;
    settle();
    outs(4'hb, 1'b1, 1'b0);
    u_ctrl.pulse_low(250);
    settle();
    outs(4'hb, 1'b1, 1'b0);
    u_ctrl.pulse_low(750);
    settle();
    outs(4'hf, 1'b1, 1'b1);
    @(negedge clk);
    ocg = 4'hb;
    settle();
    outs(4'h4, 1'b1, 1'b0);
    @(negedge clk);
    ocg = 4'h0;
    u_ctrl.pulse_low(750);
    settle();
    outs(4'hf, 1'b1, 1'b1);
  endtask : t_ocp
  task automatic t_thermal;
    set_mon(4'h2);
    outs(4'h0, 1'b0, 1'b0);
    set_mon(4'h0);
    u_ctrl.pulse_low(750);
    settle();
    outs(4'h0, 1'b0, 1'b0);
    set_mon(4'h1);
    u_ctrl.pulse_low(1500);
    settle();
    check({7'h0, f_line}, 8'h01);
    set_mon(4'h0);
    wait_ready();
  endtask : t_thermal
  task automatic t_sleep;
    u_ctrl.set_pin(1'b0);
    settle();
    outs(4'h0, 1'b1, 1'b1);
    repeat (3100) @(negedge clk);
    outs(4'h0, 1'b0, 1'b1);
    u_ctrl.set_pin(1'b1);
    wait_ready();
    outs(4'hf, 1'b1, 1'b1);
  endtask : t_sleep
  task automatic t_logic_supply;
    @(negedge clk);
    supply_ok = 1'b0;
    settle();
    outs(4'h0, 1'b0, 1'b1);
    supply_ok = 1'b1;
    wait_ready();
  endtask : t_logic_supply
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    settle();
    outs(4'h0, 1'b0, 1'b1);
    u_ctrl.set_pin(1'b1);
    wait_ready();
    outs(4'hf, 1'b1, 1'b1);
    t_supply();
    t_pump();
    t_ocp();
    t_thermal();
    t_sleep();
    t_logic_supply();
    finish_test();
  end
endmodule : halfbridge_fault_sleep_supervisor_tb
`default_nettype wire

// ===== bench/hbfs_ctrl_model.sv
`default_nettype none
module hbfs_ctrl_model (
  // Clock
  input wire logic clk,
  // Fault line from the device
  input wire logic fault_o,
  input wire logic fault_oe,
  // Controller side
  output logic sleep_control_pin_n,
  output logic fault_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds the released line high
  assign fault_line = fault_oe ? fault_o : 1'b1;
  initial sleep_control_pin_n = 1'b0;
  task automatic set_pin(input logic v);
    @(negedge clk);
    sleep_control_pin_n = v;
  endtask : set_pin
  // Low pulse measured in clock cycles
  task automatic pulse_low(input int cyc);
    set_pin(1'b0);
    repeat (cyc) @(negedge clk);
    sleep_control_pin_n = 1'b1;
  endtask : pulse_low
endmodule : hbfs_ctrl_model
`default_nettype wire

// ===== rtl/hbfs_ocp_filter.sv
`default_nettype none
module hbfs_ocp_filter #(
  parameter int FILT_CYC = hbfs_pkg::OCP_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Limit indication and clear
  input wire logic limit,
  input wire logic clear,
  output logic trip
);
  localparam int CW = $clog2(FILT_CYC + 2);
  localparam logic [CW-1:0] LIM = CW'(FILT_CYC);
  logic [CW-1:0] cnt_reg;
  wire logic expired = limit && (cnt_reg >= LIM);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      trip <= 1'b0;
    end else begin
      cnt_reg <= !limit ? '0 : (expired ? cnt_reg : cnt_reg + 1'b1);
      // Set wins over clear
      if (expired) begin
        trip <= 1'b1;
      end else if (clear) begin
        trip <= 1'b0;
      end
    end
  end
endmodule : hbfs_ocp_filter
`default_nettype wire

// ===== rtl/hbfs_pkg.sv
`default_nettype none
package hbfs_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int NUM_CH = 4;
  // Times in microseconds as specified; wake and filter are plain defaults
  localparam int CLEAR_MIN_US = 20;
  localparam int CLEAR_MAX_US = 40;
  localparam int AMBIG_MAX_US = 120;
  localparam int SLEEP_ENTRY_US = 120;
  localparam int WAKE_US = 1000;
  localparam int OCP_FILTER_US = 2;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int CLEAR_MIN_CYC = CLEAR_MIN_US * CYC_PER_US;
  localparam int CLEAR_MAX_CYC = CLEAR_MAX_US * CYC_PER_US;
  localparam int AMBIG_MAX_CYC = AMBIG_MAX_US * CYC_PER_US;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CYC_PER_US;
  localparam int WAKE_CYC = WAKE_US * CYC_PER_US;
  localparam int OCP_FILTER_CYC = OCP_FILTER_US * CYC_PER_US;
  localparam int PW_W = 16;
  localparam logic [1:0] FAULT_N_RESET = 2'h1;

  typedef struct packed {
    logic supply_uv;
    logic pump_uv;
    logic temp_over;
    logic temp_below_hys;
  } hbfs_mon_t;

  typedef enum logic [1:0] {
    HBFS_SLEEP = 2'b00,
    HBFS_WAKE = 2'b01,
    HBFS_ACTIVE = 2'b10
  } hbfs_state_t;
endpackage : hbfs_pkg
`default_nettype wire

// ===== rtl/hbfs_supervisor.sv
// Contract
// - Supply undervoltage disables all bridges and pulls fault low.
// - Supply undervoltage also stops the charge pump.
// - Supply undervoltage recovery is automatic once it clears.
// - Pump-rail undervoltage disables bridges, pulls fault low, pump stays on.
// - Pump-rail undervoltage recovery is automatic once it clears.
// - Overcurrent past filter time disables only that half-bridge, fault low.
// - Overcurrent stays latched until sleep-pin clear pulse or power cycle.
// - Overtemperature disables all outputs, stops pump, pulls fault low.
// - Thermal latch clears only after cooling below hysteresis plus clear pulse.
// - Logic held in reset while regulated logic supply is low.
// - After sleep pin falls, wait sleep-entry delay then sleep.
// - In sleep all outputs and charge pump are off.
// - Sleep pin high wakes the device automatically.
// - Active only with sleep pin high and supply good; wake delay first.
// - Low pulse of 20 to 40 us clears faults without sleep.
// - Low time 40 to 120 us clears faults; sleep optional.
// - Clear pulse changes only fault latches, not pump or other blocks.
// - Fault output released after power-up with no fault.
// - Sleep pin low puts every bridge output in high impedance.
`default_nettype none
module hbfs_supervisor #(
  parameter int NCH = hbfs_pkg::NUM_CH,
  parameter int SLEEP_CYC = hbfs_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_DLY_CYC = hbfs_pkg::WAKE_CYC,
  parameter int OCP_CYC = hbfs_pkg::OCP_FILTER_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Regulated logic supply good (low holds logic in reset)
  input wire logic logic_supply_ok,
  // Pins and monitors
  input wire logic sleep_control_pin_n,
  input wire hbfs_pkg::hbfs_mon_t mon,
  input wire logic [NCH-1:0] overcurrent_guard,
  // Outputs
  output logic [NCH-1:0] bridge_enable,
  output logic pump_enable,
  output logic ready_for_inputs,
  output logic fault_indicator_out_n_o,
  output logic fault_indicator_out_n_oe
);
  localparam int PW = hbfs_pkg::PW_W;
  localparam logic [PW-1:0] CLR_MIN = PW'(hbfs_pkg::CLEAR_MIN_CYC);
  localparam logic [PW-1:0] AMB_MAX = PW'(hbfs_pkg::AMBIG_MAX_CYC);
  localparam logic [PW-1:0] SLP_CYC = PW'(SLEEP_CYC);
  localparam int WW = $clog2(WAKE_DLY_CYC + 2);
  localparam logic [WW-1:0] WAKE_LIM = WW'(WAKE_DLY_CYC);

  // Internal reset follows logic supply
  wire logic irst_n = rst_n && logic_supply_ok;

  // Pin synchronisation
  wire logic [4:0] raw_in = {sleep_control_pin_n, mon};
  wire logic [4:0] syn;
  hbfs_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(irst_n),
    .d(raw_in),
    .q(syn)
  );
  wire logic sleep_hi = syn[4];
  wire logic s_uv = syn[3];
  wire logic p_uv = syn[2];
  wire logic t_over = syn[1];
  wire logic t_cool = syn[0];

  logic sleep_hi_d_reg;
  logic [PW-1:0] low_cnt_reg;
  hbfs_pkg::hbfs_state_t state_reg;
  logic [WW-1:0] wake_cnt_reg;
  logic therm_latch_reg;

  wire logic rise = sleep_hi && !sleep_hi_d_reg;
  // Low time measured at the rising edge
  wire logic clear_pulse = rise && (low_cnt_reg > CLR_MIN)
                           && (low_cnt_reg < AMB_MAX);
  wire logic sleep_go = !sleep_hi && (low_cnt_reg >= SLP_CYC);

  // Overcurrent filters per half-bridge
  wire logic [NCH-1:0] ocp_trip;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ocp
      hbfs_ocp_filter #(.FILT_CYC(OCP_CYC)) u_ocp (
        .clk(clk),
        .rst_n(irst_n),
        .limit(overcurrent_guard[g]),
        .clear(clear_pulse),
        .trip(ocp_trip[g])
      );
    end
  endgenerate

  wire logic therm_clr = clear_pulse && t_cool && !t_over;
  wire logic therm_next = t_over || (therm_latch_reg && !therm_clr);
  wire logic awake = (state_reg != hbfs_pkg::HBFS_SLEEP);
  wire logic all_off = s_uv || p_uv || therm_latch_reg || !sleep_hi;
  wire logic [NCH-1:0] be_next = all_off ? '0 : ~ocp_trip;
  wire logic pump_next = awake && !s_uv && !therm_latch_reg;
  wire logic any_fault = s_uv || p_uv || therm_latch_reg || (|ocp_trip);

  hbfs_pkg::hbfs_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hbfs_pkg::HBFS_SLEEP: begin
        if (sleep_hi) begin
          state_next = hbfs_pkg::HBFS_WAKE;
        end
      end
      hbfs_pkg::HBFS_WAKE: begin
        if (sleep_go) begin
          state_next = hbfs_pkg::HBFS_SLEEP;
        end else if (sleep_hi && !s_uv && wake_cnt_reg >= WAKE_LIM) begin
          state_next = hbfs_pkg::HBFS_ACTIVE;
        end
      end
      default: begin
        if (sleep_go) begin
          state_next = hbfs_pkg::HBFS_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!irst_n) begin
      sleep_hi_d_reg <= 1'b0;
      low_cnt_reg <= '0;
      state_reg <= hbfs_pkg::HBFS_SLEEP;
      wake_cnt_reg <= '0;
      therm_latch_reg <= 1'b0;
      bridge_enable <= '0;
      pump_enable <= 1'b0;
      ready_for_inputs <= 1'b0;
      fault_indicator_out_n_o <= 1'b0;
      fault_indicator_out_n_oe <= 1'b0;
    end else begin
      sleep_hi_d_reg <= sleep_hi;
      low_cnt_reg <= sleep_hi ? (rise ? low_cnt_reg : '0)
                   : ((&low_cnt_reg) ? low_cnt_reg : low_cnt_reg + 1'b1);
      if (sleep_hi && !rise) begin
        low_cnt_reg <= '0;
      end
      state_reg <= state_next;
      wake_cnt_reg <= (state_reg == hbfs_pkg::HBFS_WAKE && s_uv == 1'b0 && sleep_hi
                       && wake_cnt_reg < WAKE_LIM) ? wake_cnt_reg + 1'b1
                      : (state_reg == hbfs_pkg::HBFS_WAKE ? wake_cnt_reg : '0);
      therm_latch_reg <= therm_next;
      bridge_enable <= (state_next == hbfs_pkg::HBFS_SLEEP) ? '0 : be_next;
      pump_enable <= pump_next && (state_next != hbfs_pkg::HBFS_SLEEP);
      ready_for_inputs <= (state_next == hbfs_pkg::HBFS_ACTIVE) && sleep_hi && !s_uv;
      fault_indicator_out_n_o <= 1'b0;
      fault_indicator_out_n_oe <= any_fault;
    end
  end

  // Assertions
  property p_supply_uv;
    @(posedge clk) disable iff (!irst_n)
      s_uv |=> (bridge_enable == '0) && !pump_enable && fault_indicator_out_n_oe;
  endproperty
  a_supply_uv: assert property (p_supply_uv) else $error("supply undervoltage not handled");

  property p_uv_off;
    @(posedge clk) disable iff (!irst_n) s_uv |=> fault_indicator_out_n_oe;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("fault not pulled on undervoltage");

  property p_uv_pump;
    @(posedge clk) disable iff (!irst_n) s_uv |=> !pump_enable;
  endproperty
  a_uv_pump: assert property (p_uv_pump) else $error("pump on in undervoltage");

  property p_uv_recover;
    @(posedge clk) disable iff (!irst_n)
      $fell(s_uv) && !p_uv && !therm_latch_reg && (ocp_trip == '0) |=> !fault_indicator_out_n_oe;
  endproperty
  a_uv_recover: assert property (p_uv_recover) else $error("no recovery from undervoltage");

  property p_pump_uv_keep;
    @(posedge clk) disable iff (!irst_n)
      p_uv && !s_uv && !therm_latch_reg && awake && (state_next != hbfs_pkg::HBFS_SLEEP)
      |=> pump_enable;
  endproperty
  a_pump_uv_keep: assert property (p_pump_uv_keep) else $error("pump stopped on rail low");

  property p_pump_uv_recover;
    @(posedge clk) disable iff (!irst_n)
      $fell(p_uv) && !s_uv && !therm_latch_reg && (ocp_trip == '0) |=> !fault_indicator_out_n_oe;
  endproperty
  a_pump_uv_recover: assert property (p_pump_uv_recover) else $error("no rail recovery");
  property p_pump_uv;
    @(posedge clk) disable iff (!irst_n) p_uv |=> (bridge_enable == '0) && fault_indicator_out_n_oe;
  endproperty
  a_pump_uv: assert property (p_pump_uv) else $error("pump rail undervoltage not handled");
  property p_therm;
    @(posedge clk) disable iff (!irst_n) t_over |=> ##1 !pump_enable && (bridge_enable == '0);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal shutdown not applied");
  property p_therm_hold;
    @(posedge clk) disable iff (!irst_n) therm_latch_reg && !clear_pulse |=> therm_latch_reg;
  endproperty
  a_therm_hold: assert property (p_therm_hold) else $error("thermal latch lost");
  generate
    for (g = 0; g < NCH; g++) begin : g_ocp_chk
      property p_ocp_off;
        @(posedge clk) disable iff (!irst_n) ocp_trip[g] |=> !bridge_enable[g];
      endproperty
      a_ocp_off: assert property (p_ocp_off) else $error("tripped bridge driven");
      property p_ocp_hold;
        @(posedge clk) disable iff (!irst_n) ocp_trip[g] && !clear_pulse |=> ocp_trip[g];
      endproperty
      a_ocp_hold: assert property (p_ocp_hold) else $error("overcurrent latch lost");
    end
  endgenerate

  property p_ocp_fault;
    @(posedge clk) disable iff (!irst_n) (|ocp_trip) |=> fault_indicator_out_n_oe;
  endproperty
  a_ocp_fault: assert property (p_ocp_fault) else $error("overcurrent not reported");

  property p_ocp_pump;
    @(posedge clk) disable iff (!irst_n)
      (|ocp_trip) && !s_uv && !therm_latch_reg && awake && (state_next != hbfs_pkg::HBFS_SLEEP)
      |=> pump_enable;
  endproperty
  a_ocp_pump: assert property (p_ocp_pump) else $error("pump stopped on overcurrent");

  property p_therm_set;
    @(posedge clk) disable iff (!irst_n) t_over |=> therm_latch_reg;
  endproperty
  a_therm_set: assert property (p_therm_set) else $error("thermal latch not set");

  property p_therm_fault;
    @(posedge clk) disable iff (!irst_n) therm_latch_reg |=> fault_indicator_out_n_oe;
  endproperty
  a_therm_fault: assert property (p_therm_fault) else $error("thermal not reported");

  property p_therm_hot;
    @(posedge clk) disable iff (!irst_n) therm_latch_reg && !t_cool |=> therm_latch_reg;
  endproperty
  a_therm_hot: assert property (p_therm_hot) else $error("thermal cleared while hot");

  // Outputs forced off while the logic supply is low
  property p_logic_reset;
    @(posedge clk)
      !irst_n |=> (bridge_enable == '0) && !pump_enable && !fault_indicator_out_n_oe;
  endproperty
  a_logic_reset: assert property (p_logic_reset) else $error("outputs live in reset");

  property p_sleep_entry;
    @(posedge clk) disable iff (!irst_n)
      (state_reg == hbfs_pkg::HBFS_ACTIVE) && sleep_go |=> state_reg == hbfs_pkg::HBFS_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_no_early_sleep;
    @(posedge clk) disable iff (!irst_n)
      (state_reg != hbfs_pkg::HBFS_SLEEP) && !sleep_go |=> state_reg != hbfs_pkg::HBFS_SLEEP;
  endproperty
  a_no_early_sleep: assert property (p_no_early_sleep) else $error("sleep too early");

  property p_sleep_bridge;
    @(posedge clk) disable iff (!irst_n)
      state_reg == hbfs_pkg::HBFS_SLEEP |-> bridge_enable == '0;
  endproperty
  a_sleep_bridge: assert property (p_sleep_bridge) else $error("bridge on in sleep");

  property p_wake;
    @(posedge clk) disable iff (!irst_n)
      (state_reg == hbfs_pkg::HBFS_SLEEP) && sleep_hi |=> state_reg == hbfs_pkg::HBFS_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on pin high");

  property p_wake_wait;
    @(posedge clk) disable iff (!irst_n)
      (state_reg == hbfs_pkg::HBFS_WAKE) && (wake_cnt_reg < WAKE_LIM) |=> !ready_for_inputs;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("ready before wake delay");

  property p_clear_no_sleep;
    @(posedge clk) disable iff (!irst_n)
      clear_pulse && (state_reg != hbfs_pkg::HBFS_SLEEP) |=> state_reg != hbfs_pkg::HBFS_SLEEP;
  endproperty
  a_clear_no_sleep: assert property (p_clear_no_sleep) else $error("sleep on clear");

  property p_clear_ocp;
    @(posedge clk) disable iff (!irst_n)
      clear_pulse && !(|overcurrent_guard) |=> ocp_trip == '0;
  endproperty
  a_clear_ocp: assert property (p_clear_ocp) else $error("overcurrent not cleared");

  property p_clear_pump;
    @(posedge clk) disable iff (!irst_n)
      clear_pulse && $stable(s_uv) && $stable(therm_latch_reg) && $stable(state_reg)
      && (state_next == state_reg) |=> $stable(pump_enable);
  endproperty
  a_clear_pump: assert property (p_clear_pump) else $error("pump changed by clear");

  property p_fault_data;
    @(posedge clk) disable iff (!irst_n) !fault_indicator_out_n_o;
  endproperty
  a_fault_data: assert property (p_fault_data) else $error("fault line driven high");

  property p_fault_set;
    @(posedge clk) disable iff (!irst_n) any_fault |=> fault_indicator_out_n_oe;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not reported");

  property p_pulse_meas;
    @(posedge clk) disable iff (!irst_n)
      !sleep_hi && !(&low_cnt_reg) |=> low_cnt_reg == $past(low_cnt_reg) + 1'b1;
  endproperty
  a_pulse_meas: assert property (p_pulse_meas) else $error("low time not counted");
  property p_sleep_low;
    @(posedge clk) disable iff (!irst_n) !sleep_hi |=> bridge_enable == '0;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("bridge driven with sleep low");
  property p_sleep_state;
    @(posedge clk) disable iff (!irst_n) state_reg == hbfs_pkg::HBFS_SLEEP |-> !pump_enable;
  endproperty
  a_sleep_state: assert property (p_sleep_state) else $error("pump on in sleep");
  property p_fault_rel;
    @(posedge clk) disable iff (!irst_n) !any_fault |=> !fault_indicator_out_n_oe;
  endproperty
  a_fault_rel: assert property (p_fault_rel) else $error("fault held without source");
  property p_ready;
    @(posedge clk) disable iff (!irst_n) ready_for_inputs |-> $past(sleep_hi) && !$past(s_uv);
  endproperty
  a_ready: assert property (p_ready) else $error("active without conditions");
endmodule : hbfs_supervisor
`default_nettype wire

// ===== rtl/hbfs_sync.sv
`default_nettype none
module hbfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [W-1:0] q_next = (agree & s3_reg) | (~agree & q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= q_next;
    end
  end
endmodule : hbfs_sync
`default_nettype wire
